// file: hdl/vsp_top.sv
// Valve set point processing and travel/pressure control selection with an AHB-Lite slave.
`timescale 1ns/1ns
// Summary of operation
// - Travel select regulates travel, pressure select regulates pressure; no fallback.
// - Sensor fallback mode goes to pressure control on travel sensor failure.
// - Deviation fallback also falls back after deviation exceeds threshold past its time.
// - Deviation is target minus travel; fallen back means pressure regulation.
// - Auto recovery returns to travel; manual returns only after switching to auto.
// - High cutoff forces target to 123% while travel is above high point.
// - Limit selectors clamp target between low and high points.
// - High point of 125% disables the high limit or cutoff.
// - Nonzero high ramp rate ramps toward the high extreme; zero jumps.
// - Low cutoff forces target to -23% while travel is below low point.
// - Low point of -25% disables the low limit or cutoff.
// - Nonzero low ramp rate ramps toward the low extreme; zero jumps.
// - Stroking enters test mode; it stays until mode is rewritten.
// - After restart, mode is always analog: reset sets the restart setting to resume and the last mode to analog.
// - Closed zero power passes set point; open replaces it with 100% minus set point.
// - Custom curve holds 21 points from -6.25% to 106.25%, linear by default.
// - Opening and closing rate limits bound target motion; zero removes limit.
// - Lag filter time 0.2 to 10 seconds; zero bypasses it.
// - Lead-lag uses lag time and direction ratios; zero lag disables it.
// - Boost presets lead-lag state low while valve is seated.
module vsp_top
    import vsp_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    output logic signed [15:0] O_TARGET,
    output logic O_PRESSURE_CTL,
    output logic O_TICK
);

    if (TICK_DIV < 2) begin : g_bad_div
        $error("TICK_DIV must be at least 2");
    end

    // ********************************************************************
    // Register bus.
    // ********************************************************************
    logic [7:0] addr_q;
    logic wr_q;
    logic ph_q;
    logic [31:0] setpoint_q, travel_q, ctrl_q, rate_q, ramp_q, clamp_q, filter_q, dev_q;
    logic [4:0] curve_idx_q;
    logic signed [15:0] curve_q [CURVE_POINTS];
    logic [1:0] mode_q;
    logic fallen_q;
    logic pressure_q;
    logic signed [15:0] stage_q;
    logic signed [15:0] rated_q, filt_q, out_q;
    logic [31:0] rdata_d;
    wire bus_go = I_HSEL && I_HREADY && I_HTRANS[1];
    wire wr_en = ph_q && wr_q;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ph_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            ph_q <= bus_go;
            if (bus_go) begin
                wr_q <= I_HWRITE;
                addr_q <= I_HADDR[7:0];
            end
        end
    end

    // Writes of the curve data port land at the point that the index selects.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            setpoint_q <= 32'h0000_0000;
            travel_q <= 32'h0000_0000;
            rate_q <= 32'h0000_0000;
            ramp_q <= 32'h0000_0000;
            clamp_q <= {PCT_HI_DEF, PCT_LO_DEF};
            filter_q <= 32'h0000_0000;
            dev_q <= {DEV_TIME_DEF, DEV_DEF};
            curve_idx_q <= 5'h00;
        end else if (wr_en) begin
            unique case (addr_q)
                REG_SETPOINT: setpoint_q <= I_HWDATA;
                REG_TRAVEL: travel_q <= I_HWDATA;
                REG_RATE: rate_q <= I_HWDATA;
                REG_RAMP: ramp_q <= I_HWDATA;
                REG_CLAMP: clamp_q <= I_HWDATA;
                REG_FILTER: filter_q <= I_HWDATA;
                REG_DEV: dev_q <= I_HWDATA;
                REG_CURVE_IDX: curve_idx_q <= I_HWDATA[4:0];
                default: ;
            endcase
        end
    end

    // The curve resets to a straight line from -6.25% in equal steps.
    for (genvar g = 0; g < CURVE_POINTS; g++) begin : g_curve
        always_ff @(posedge I_CLK or negedge I_RSTN) begin
            if (!I_RSTN) begin
                curve_q[g] <= 16'(PCT_M625 + g * PCT_STEP);
            end else if (wr_en && addr_q == REG_CURVE_DAT && curve_idx_q == 5'(g)) begin
                curve_q[g] <= I_HWDATA[15:0];
            end
        end
    end

    always_comb begin
        unique case (I_HADDR[7:0])
            REG_SETPOINT: rdata_d = setpoint_q;
            REG_TRAVEL: rdata_d = travel_q;
            REG_CTRL: rdata_d = ctrl_q;
            REG_RATE: rdata_d = rate_q;
            REG_RAMP: rdata_d = ramp_q;
            REG_CLAMP: rdata_d = clamp_q;
            REG_FILTER: rdata_d = filter_q;
            REG_DEV: rdata_d = dev_q;
            REG_STATUS: rdata_d = {28'h0, mode_q, fallen_q, pressure_q};
            REG_TARGET: rdata_d = {{16{out_q[15]}}, out_q};
            REG_CURVE_IDX: rdata_d = {27'h0, curve_idx_q};
            REG_CURVE_DAT: rdata_d = (curve_idx_q < 5'(CURVE_POINTS)) ?
                {{16{curve_q[curve_idx_q][15]}}, curve_q[curve_idx_q]} : 32'h0;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_HRDATA <= 32'h0000_0000;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
        end else begin
            O_HRDATA <= (bus_go && !I_HWRITE) ? rdata_d : 32'h0;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
        end
    end

    // ********************************************************************
    // Control register and mode tracking.
    // ********************************************************************
    wire [1:0] sel = ctrl_q[CTRL_SEL_LSB +: 2];
    wire auto_rec = ctrl_q[CTRL_AUTO_BIT];
    wire [1:0] restart_sel = ctrl_q[CTRL_RESTART_LSB +: 2];
    wire stroke = ctrl_q[CTRL_STROKE_BIT];
    wire sensor_fail = ctrl_q[CTRL_SENSOR_BIT];
    wire seated = ctrl_q[CTRL_SEATED_BIT];
    logic [1:0] last_mode_q;
    logic started_q;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_en && addr_q == REG_CTRL) begin
            ctrl_q <= I_HWDATA;
        end
    end

    // The resume choice keeps the mode held in last_mode_q, which reset clears to MODE_ANALOG.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            mode_q <= MODE_ANALOG;
            last_mode_q <= MODE_ANALOG;
            started_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
            last_mode_q <= mode_q;
            if (!started_q) begin
                unique case (restart_sel)
                    RESTART_ANALOG: mode_q <= MODE_ANALOG;
                    RESTART_DIGITAL: mode_q <= MODE_DIGITAL;
                    default: mode_q <= last_mode_q;
                endcase
            end else if (wr_en && addr_q == REG_CTRL &&
                         I_HWDATA[CTRL_MODE_LSB +: 2] != 2'(MODE_TEST)) begin
                mode_q <= I_HWDATA[CTRL_MODE_LSB +: 2];
            end else if (stroke) begin
                mode_q <= MODE_TEST;
            end
        end
    end

    // ********************************************************************
    // Sample tick.
    // ********************************************************************
    logic [31:0] div_q;
    wire tick = (div_q == 32'(TICK_DIV - 1));

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            div_q <= 32'h0;
            O_TICK <= 1'b0;
        end else begin
            div_q <= tick ? 32'h0 : div_q + 32'h1;
            O_TICK <= tick;
        end
    end

    // ********************************************************************
    // Fallback selection.
    // ********************************************************************
    logic [15:0] dev_cnt_q;
    logic [9:0] sec_q;
    wire signed [15:0] travel = travel_q[15:0];
    wire signed [16:0] dev_raw = 17'(out_q) - 17'(travel);
    wire [16:0] dev_abs = dev_raw[16] ? 17'(-dev_raw) : dev_raw;
    wire dev_over = dev_abs > 17'(dev_q[15:0]);

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            dev_cnt_q <= 16'h0;
            sec_q <= 10'h0;
        end else if (tick) begin
            // Deviation time counts whole seconds of continuous excess.
            if (!dev_over || sel != SEL_FB_DEVIATION) begin
                dev_cnt_q <= 16'h0;
                sec_q <= 10'h0;
            end else if (sec_q == 10'(TICKS_PER_SEC - 1)) begin
                sec_q <= 10'h0;
                if (dev_cnt_q != 16'hFFFF) begin
                    dev_cnt_q <= dev_cnt_q + 16'h1;
                end
            end else begin
                sec_q <= sec_q + 10'h1;
            end
        end
    end

    wire fb_trig = (sel == SEL_FB_SENSOR && sensor_fail) ||
                   (sel == SEL_FB_DEVIATION &&
                    (sensor_fail || dev_cnt_q > dev_q[31:16]));
    wire recover = auto_rec && !sensor_fail && !(dev_over && sel == SEL_FB_DEVIATION);

    // A fresh trigger wins over recovery in the same cycle.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            fallen_q <= 1'b0;
            pressure_q <= 1'b0;
            O_PRESSURE_CTL <= 1'b0;
        end else begin
            if (sel == SEL_TRAVEL || sel == SEL_PRESSURE) begin
                fallen_q <= 1'b0;
            end else if (fb_trig) begin
                fallen_q <= 1'b1;
            end else if (recover) begin
                fallen_q <= 1'b0;
            end
            pressure_q <= (sel == SEL_PRESSURE) || (fallen_q && sel != SEL_TRAVEL);
            O_PRESSURE_CTL <= pressure_q;
        end
    end

    // ********************************************************************
    // Set point processing pipeline, one step per tick.
    // ********************************************************************
    function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
        if (v > 18'sh07FFF) begin
            sat16 = 16'sh7FFF;
        end else if (v < -18'sh08000) begin
            sat16 = -16'sh8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction : sat16

    function automatic logic signed [15:0] step_to(input logic signed [15:0] cur,
                                                  input logic signed [15:0] goal,
                                                  input logic [15:0] up,
                                                  input logic [15:0] dn);
        logic signed [17:0] nx;
        nx = 18'(cur);
        if (goal > cur && up != 16'h0 && 18'(goal) - 18'(cur) > 18'(up)) begin
            nx = 18'(cur) + 18'(up);
        end else if (goal < cur && dn != 16'h0 && 18'(cur) - 18'(goal) > 18'(dn)) begin
            nx = 18'(cur) - 18'(dn);
        end else begin
            nx = 18'(goal);
        end
        step_to = sat16(nx);
    endfunction : step_to

    wire signed [15:0] sp = setpoint_q[15:0];
    wire signed [15:0] ranged = ctrl_q[CTRL_ZPC_BIT] ? 16'(PCT_100 - sp) : sp;
    wire signed [16:0] rel = 17'(ranged) - 17'(PCT_M625);
    logic [4:0] seg;
    logic signed [15:0] frac, y0, y1, chard;

    // Piecewise-linear lookup across the 21 points; ends hold flat.
    always_comb begin
        seg = 5'h0;
        frac = 16'sh0;
        if (rel < 0) begin
            seg = 5'h0;
        end else if (rel >= 17'(20 * PCT_STEP)) begin
            seg = 5'd19;
            frac = PCT_STEP;
        end else begin
            seg = 5'(rel / 17'(PCT_STEP));
            frac = 16'(rel - 17'(seg) * 17'(PCT_STEP));
        end
        y0 = curve_q[seg];
        y1 = curve_q[seg + 5'h1];
        chard = 16'(32'(y0) + (32'(y1 - y0) * 32'(frac)) / 32'(PCT_STEP));
    end

    wire signed [15:0] hi_pt = clamp_q[31:16];
    wire signed [15:0] lo_pt = clamp_q[15:0];
    wire hi_on = hi_pt != PCT_125;
    wire lo_on = lo_pt != PCT_M25;
    wire hcut = ctrl_q[CTRL_HCUT_BIT];
    wire lcut = ctrl_q[CTRL_LCUT_BIT];
    wire [15:0] lag_t = filter_q[15:0];
    wire lead_mode = ctrl_q[CTRL_LEADLAG_BIT];
    wire [7:0] ratio_op = filter_q[23:16];
    wire [7:0] ratio_cl = filter_q[31:24];
    logic signed [31:0] lag_acc_q;
    logic signed [15:0] filt_d, clamp_d;

    // Lag time is in tenths of a second; coefficient is one tick over the time constant.
    always_comb begin
        logic signed [31:0] lagv, lead;
        lagv = lag_acc_q >>> PCT_FRAC;
        lead = 32'sh0;
        if (lag_t == 16'h0) begin
            filt_d = rated_q;
        end else if (lead_mode) begin
            lead = 32'(rated_q) - lagv;
            lead = (rated_q >= 16'(lagv)) ? (lead * int'(ratio_op)) >>> 4
                : (lead * int'(ratio_cl)) >>> 4;
            filt_d = sat16(18'(lagv + lead));
        end else begin
            filt_d = 16'(lagv);
        end
        clamp_d = filt_q;
        if (hi_on && hcut && travel > hi_pt) begin
            clamp_d = step_to(out_q, PCT_123, ramp_q[15:0], 16'h0);
        end else if (lo_on && lcut && travel < lo_pt) begin
            clamp_d = step_to(out_q, PCT_M23, 16'h0, ramp_q[31:16]);
        end else begin
            if (hi_on && !hcut && clamp_d > hi_pt) clamp_d = hi_pt;
            if (lo_on && !lcut && clamp_d < lo_pt) clamp_d = lo_pt;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            stage_q <= PCT_0;
            rated_q <= PCT_0;
            filt_q <= PCT_0;
            out_q <= PCT_0;
            lag_acc_q <= 32'sh0;
            O_TARGET <= PCT_0;
        end else if (tick) begin
            stage_q <= chard;
            rated_q <= step_to(rated_q, stage_q, rate_q[15:0], rate_q[31:16]);
            filt_q <= filt_d;
            out_q <= clamp_d;
            O_TARGET <= clamp_d;
            if (ctrl_q[CTRL_BOOST_BIT] && seated && lead_mode) begin
                lag_acc_q <= 32'(PCT_M23) <<< PCT_FRAC;
            end else if (lag_t == 16'h0) begin
                lag_acc_q <= 32'(rated_q) <<< PCT_FRAC;
            end else begin
                lag_acc_q <= lag_acc_q + ((32'(rated_q) <<< PCT_FRAC) - lag_acc_q)
                             / (int'(lag_t) * 32'(TICKS_PER_SEC / 10));
            end
        end
    end

endmodule : vsp_top

// file: pkg/vsp_pkg.sv
// Package for the valve set point processing block: register map, encodings and constants.
package vsp_pkg;

    // ********************************************************************
    // Fixed point: percent of travel times 256, signed 16 bits.
    // ********************************************************************
    localparam int PCT_FRAC = 8;
    localparam logic signed [15:0] PCT_0 = 16'sh0000;
    localparam logic signed [15:0] PCT_100 = 16'sh6400;
    localparam logic signed [15:0] PCT_123 = 16'sh7B00;
    localparam logic signed [15:0] PCT_M23 = -16'sh1700;
    localparam logic signed [15:0] PCT_125 = 16'sh7D00;
    localparam logic signed [15:0] PCT_M25 = -16'sh1900;
    localparam logic signed [15:0] PCT_M625 = -16'sh0640;
    localparam logic signed [15:0] PCT_STEP = 16'sh05A0;
    localparam logic signed [15:0] PCT_HI_DEF = 16'sh7D00;
    localparam logic signed [15:0] PCT_LO_DEF = -16'sh1900;
    localparam logic signed [15:0] DEV_DEF = 16'sh0500;
    localparam int CURVE_POINTS = 21;

    // ********************************************************************
    // Timing: the sample tick and one second expressed as ticks.
    // ********************************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int SAMPLE_HZ = 1000;
    localparam int TICK_CYCLES = CLK_HZ / SAMPLE_HZ;
    localparam int TICKS_PER_SEC = SAMPLE_HZ;
    localparam logic [15:0] DEV_TIME_DEF = 16'h03E7;

    // ********************************************************************
    // Register byte offsets.
    // ********************************************************************
    localparam logic [7:0] REG_SETPOINT = 8'h00;
    localparam logic [7:0] REG_TRAVEL = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_RATE = 8'h0C;
    localparam logic [7:0] REG_RAMP = 8'h10;
    localparam logic [7:0] REG_CLAMP = 8'h14;
    localparam logic [7:0] REG_FILTER = 8'h18;
    localparam logic [7:0] REG_DEV = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_TARGET = 8'h24;
    localparam logic [7:0] REG_CURVE_IDX = 8'h28;
    localparam logic [7:0] REG_CURVE_DAT = 8'h2C;

    // CTRL fields.
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_ZPC_BIT = 2;
    localparam int CTRL_AUTO_BIT = 3;
    localparam int CTRL_HCUT_BIT = 4;
    localparam int CTRL_LCUT_BIT = 5;
    localparam int CTRL_CHAR_BIT = 6;
    localparam int CTRL_LEADLAG_BIT = 7;
    localparam int CTRL_BOOST_BIT = 8;
    localparam int CTRL_MODE_LSB = 9;
    localparam int CTRL_RESTART_LSB = 11;
    localparam int CTRL_STROKE_BIT = 13;
    localparam int CTRL_SENSOR_BIT = 14;
    localparam int CTRL_SEATED_BIT = 15;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0200;

    typedef enum logic [1:0] {
        SEL_TRAVEL, SEL_PRESSURE, SEL_FB_SENSOR, SEL_FB_DEVIATION
    } vsp_sel_e;

    typedef enum logic [1:0] {MODE_ANALOG, MODE_DIGITAL, MODE_TEST} vsp_mode_e;

    typedef enum logic [1:0] {RESTART_RESUME, RESTART_ANALOG, RESTART_DIGITAL} vsp_restart_e;

    typedef struct packed {
        logic signed [15:0] target;
        logic pressure_ctl;
        logic fallen_back;
        vsp_mode_e mode;
    } vsp_out_s;

endpackage : vsp_pkg

// file: verification/vsp_checker.sv
// Concurrent checks on the ports of the set point processing block.
`timescale 1ns/1ns
module vsp_checker
    import vsp_pkg::*;
#(
    parameter int TICK_DIV = 8
) (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    input wire logic [31:0] O_HRDATA,
    input wire logic O_HREADYOUT,
    input wire logic O_HRESP,
    input wire logic signed [15:0] O_TARGET,
    input wire logic O_PRESSURE_CTL,
    input wire logic O_TICK
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    // ********************************************************************
    // Helper logic: a shadow of the control word and a tick spacing counter.
    // ********************************************************************
    logic wr_q;
    logic rd_q;
    logic [7:0] adr_q;
    logic [31:0] ctrl_q;
    int cnt_q;
    logic seen_q;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            adr_q <= 8'h00;
        end else begin
            wr_q <= I_HSEL && I_HREADY && I_HTRANS[1] && I_HWRITE;
            rd_q <= I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE;
            adr_q <= I_HADDR[7:0];
        end
    end
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_q && adr_q == REG_CTRL) begin
            ctrl_q <= I_HWDATA;
        end
    end
    // The first tick after reset has no predecessor, so its spacing is not judged.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cnt_q <= 0;
            seen_q <= 1'b0;
        end else begin
            cnt_q <= O_TICK ? 0 : cnt_q + 1;
            seen_q <= seen_q || O_TICK;
        end
    end
    // ********************************************************************
    // Assertions.
    // ********************************************************************
    tick_period_a: assert property (O_TICK && seen_q |-> cnt_q == TICK_DIV - 1)
        else $error("tick spacing wrong");
    target_hold_a: assert property (!$stable(O_TARGET) |-> O_TICK)
        else $error("target moved between ticks");
    target_range_a: assert property (O_TARGET >= PCT_M23 && O_TARGET <= PCT_123)
        else $error("target outside cutoff extremes");
    press_sel_a: assert property (ctrl_q[1:0] == 2'd1 [*3] |-> O_PRESSURE_CTL)
        else $error("pressure select not obeyed");
    travel_sel_a: assert property (ctrl_q[1:0] == 2'd0 [*3] |-> !O_PRESSURE_CTL)
        else $error("travel select not obeyed");
    sensor_fb_a: assert property ((ctrl_q[1] && ctrl_q[CTRL_SENSOR_BIT]) [*4] |-> O_PRESSURE_CTL)
        else $error("no fallback on sensor failure");
    manual_hold_a: assert property ((O_PRESSURE_CTL && ctrl_q[1] && !ctrl_q[CTRL_AUTO_BIT]) [*3]
        |=> O_PRESSURE_CTL)
        else $error("manual recovery left fallback");
    auto_recov_a: assert property ((ctrl_q[1:0] == 2'd2 && ctrl_q[CTRL_AUTO_BIT]
        && !ctrl_q[CTRL_SENSOR_BIT]) [*4] |-> !O_PRESSURE_CTL)
        else $error("auto recovery did not return");
    unmapped_zero_a: assert property (rd_q && adr_q > REG_CURVE_DAT |-> O_HRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    okay_resp_a: assert property (O_HREADYOUT && !O_HRESP)
        else $error("wait state or error response");
endmodule : vsp_checker
bind vsp_top vsp_checker #(.TICK_DIV(TICK_DIV)) u_chk (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
    .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
    .I_HSIZE(I_HSIZE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_TARGET(O_TARGET),
    .O_PRESSURE_CTL(O_PRESSURE_CTL), .O_TICK(O_TICK));

// file: verification/valve_setpoint_processing_bench.sv
// Self-checking bench for the set point processing block.
`timescale 1ns/1ns
module valve_setpoint_processing_bench;
    import vsp_pkg::*;
    logic I_CLK = 1'b0;
    logic I_RSTN = 1'b0;
    logic I_HSEL = 1'b0;
    logic [31:0] I_HADDR = 32'h0;
    logic [1:0] I_HTRANS = 2'h0;
    logic I_HWRITE = 1'b0;
    logic [2:0] I_HSIZE = 3'h2;
    logic [31:0] I_HWDATA = 32'h0;
    wire logic I_HREADY;
    logic [31:0] O_HRDATA;
    logic O_HREADYOUT;
    logic O_HRESP;
    logic signed [15:0] O_TARGET;
    logic O_PRESSURE_CTL;
    logic O_TICK;
    int fails = 0;
    int compares = 0;
    int seed = 20;
    int cyc = 0;
    logic rd_dp = 1'b0;
    logic [31:0] exp_q[$];
    assign I_HREADY = O_HREADYOUT;
    always #10 I_CLK = ~I_CLK;
    vsp_top #(.TICK_DIV(8)) u_dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_HSEL(I_HSEL),
        .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE),
        .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
        .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_TARGET(O_TARGET),
        .O_PRESSURE_CTL(O_PRESSURE_CTL), .O_TICK(O_TICK));
    // ********************************************************************
    // Compare, verdict and bus tasks.
    // ********************************************************************
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_rd
    task automatic cmp_out(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_out
    task automatic give_verdict();
        $display("counts: fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        I_HSEL <= 1'b1;
        I_HTRANS <= 2'h2;
        I_HADDR <= {24'h0, a};
        I_HWRITE <= wr;
        do @(posedge I_CLK); while (I_HREADY !== 1'b1);
        I_HSEL <= 1'b0;
        I_HTRANS <= 2'h0;
        I_HWDATA <= wr ? d : $random(seed);
        rd_dp <= !wr;
        do @(posedge I_CLK); while (I_HREADY !== 1'b1);
        rd_dp <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic ticks(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge I_CLK);
                k++;
            end while (O_TICK !== 1'b1 && k < 100);
        end
        repeat (2) @(posedge I_CLK);
        #1;
    endtask : ticks
    // Fallback reaches the pressure pin three edges after its cause.
    task automatic see_p(input logic e);
        repeat (3) @(posedge I_CLK);
        #1;
        cmp_out({15'h0, O_PRESSURE_CTL}, {15'h0, e});
    endtask : see_p
    // Read data is judged at the edge that closes the read's data phase.
    always @(posedge I_CLK) begin
        if (rd_dp && I_HREADY === 1'b1) begin
            cmp_rd(O_HRDATA, exp_q.pop_front());
        end
    end
    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            give_verdict();
        end
    end
    // ********************************************************************
    // Main sequence.
    // ********************************************************************
    initial begin
        repeat (5) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        rd(REG_CTRL, CTRL_RESET);
        rd(REG_CLAMP, {PCT_125, PCT_M25});
        rd(REG_DEV, {DEV_TIME_DEF, DEV_DEF});
        rd(REG_STATUS, 32'h0);
        bus(1'b1, 8'h30, $random(seed));
        rd(8'h30, 32'h0);
        $display("test reset and map done");
        bus(1'b1, REG_CTRL, 32'h201);
        see_p(1'b1);
        bus(1'b1, REG_CTRL, 32'h200);
        see_p(1'b0);
        bus(1'b1, REG_CTRL, 32'h4202);
        see_p(1'b1);
        bus(1'b1, REG_CTRL, 32'h202);
        see_p(1'b1);
        bus(1'b1, REG_CTRL, 32'h20A);
        see_p(1'b0);
        bus(1'b1, REG_DEV, 32'h0001_0100);
        bus(1'b1, REG_TRAVEL, 32'hF600);
        bus(1'b1, REG_CTRL, 32'h203);
        repeat (15000) @(posedge I_CLK);
        see_p(1'b0);
        repeat (2000) @(posedge I_CLK);
        see_p(1'b1);
        rd(REG_STATUS, 32'h7);
        bus(1'b1, REG_CTRL, 32'h20B);
        see_p(1'b1);
        bus(1'b1, REG_TRAVEL, 32'h0);
        ticks(2);
        see_p(1'b0);
        $display("test control select done");
        bus(1'b1, REG_CTRL, 32'h200);
        bus(1'b1, REG_SETPOINT, 32'h2640);
        ticks(8);
        cmp_out(O_TARGET, 16'h2640);
        bus(1'b1, REG_CTRL, 32'h204);
        ticks(8);
        cmp_out(O_TARGET, 16'h3DC0);
        bus(1'b1, REG_CTRL, 32'h200);
        bus(1'b1, REG_CLAMP, 32'h2000_E700);
        ticks(8);
        cmp_out(O_TARGET, 16'h2000);
        bus(1'b1, REG_CLAMP, 32'h7D00_2800);
        ticks(8);
        cmp_out(O_TARGET, 16'h2800);
        bus(1'b1, REG_CTRL, 32'h210);
        bus(1'b1, REG_CLAMP, 32'h6380_E700);
        bus(1'b1, REG_TRAVEL, 32'h6400);
        ticks(8);
        cmp_out(O_TARGET, 16'h7B00);
        bus(1'b1, REG_CLAMP, 32'h7D00_E700);
        ticks(8);
        cmp_out(O_TARGET, 16'h2640);
        bus(1'b1, REG_CTRL, 32'h220);
        bus(1'b1, REG_CLAMP, 32'h7D00_0080);
        bus(1'b1, REG_TRAVEL, 32'h0);
        ticks(8);
        cmp_out(O_TARGET, 16'hE900);
        bus(1'b1, REG_RATE, 32'h0000_0100);
        bus(1'b1, REG_CTRL, 32'h204);
        ticks(10);
        cmp_out({15'h0, O_TARGET < 16'sh3DC0}, 16'h1);
        ticks(50);
        cmp_out(O_TARGET, 16'h3DC0);
        $display("test target path done");
        bus(1'b1, REG_CTRL, 32'h2200);
        rd(REG_STATUS, 32'h8);
        bus(1'b1, REG_CTRL, 32'h0000);
        rd(REG_STATUS, 32'h0);
        $display("test control mode done");
        repeat (2) @(posedge I_CLK);
        give_verdict();
    end
endmodule : valve_setpoint_processing_bench
